// ==== sfm_sync.sv ====
// Package of shared constants and carriers, plus the pin synchroniser with clock edge finder
package sfm_pkg;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned ADDR_W = 19;
  localparam logic [18:0] DEPTH_LAST = 19'h40076;  // 262263 words, last address
  localparam logic [18:0] ADDR_ZERO = 19'h00000;
  localparam int unsigned OLD_W = 7;
  localparam logic [18:0] OLD_DEPTH = 19'h00080;   // Words kept aside for old-field reads
  localparam logic [6:0] OLD_LIMIT = 7'h77;        // 119 write clocks after a write reset
  localparam logic [3:0] DOUT_RESET = 4'h0;
  localparam int unsigned WR_PIN_W = 8;
  localparam int unsigned RD_PIN_W = 4;

  // Write-side pins after synchronising
  typedef struct packed {
    logic [3:0] nibble;
    logic clear;
    logic mask_on;
    logic gate;
    logic shift_clock;
  } sfm_wr_pins_t;

  // Read-side pins after synchronising
  typedef struct packed {
    logic clear;
    logic drive_on;
    logic gate;
    logic shift_clock;
  } sfm_rd_pins_t;
endpackage

`timescale 1ns/1ns

module sfm_sync #(
  parameter int unsigned W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Raw pins, bit 0 is the shift clock
  input wire logic [W-1:0] din,
  // Synchronised pins and clock rising edge
  output logic [W-1:0] dout,
  output logic rise
);
  logic [W-1:0] meta;
  logic last_clk;

  // Two flops per pin; the first is read only by the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

  // Previous clock level for edge finding
  always_ff @(posedge clk) begin
    if (srst) begin
      last_clk <= 1'b0;
    end else begin
      last_clk <= dout[0];
    end
  end

  assign rise = dout[0] & ~last_clk;
endmodule // sfm_sync

// ==== sfm_field_fifo.sv ====
// Serial field FIFO memory, 4 bits wide, with separate write and read shift ports
`timescale 1ns/1ns

module sfm_field_fifo (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Write port pins
  input wire logic input_shift_clock,
  input wire logic input_advance_gate,
  input wire logic input_mask_on,
  input wire logic input_pointer_clear,
  input wire logic [3:0] input_nibble,
  // Read port pins
  input wire logic output_shift_clock,
  input wire logic output_advance_gate,
  input wire logic output_drive_on,
  input wire logic output_pointer_clear,
  // Data outputs
  output logic [3:0] output_nibble,
  output logic output_nibble_oe
);
  sfm_pkg::sfm_wr_pins_t wr_s;
  sfm_pkg::sfm_rd_pins_t rd_s;
  logic wr_edge;
  logic rd_edge;
  logic [18:0] wr_ptr;
  logic [18:0] rd_ptr;
  logic pend_v;
  logic pend_mask;
  logic [18:0] pend_addr;
  logic [3:0] pend_data;
  logic commit;
  logic [6:0] since_wrst;
  logic fresh;
  logic use_old;
  logic [3:0] mem [0:262262];
  logic [3:0] old_buf [0:127];
  logic [127:0] old_sv;

  // Pointer step with wrap at the last word; decoding shared by both ports
  function automatic logic [18:0] ptr_inc(input logic [18:0] p);
    ptr_inc = (p == sfm_pkg::DEPTH_LAST) ? sfm_pkg::ADDR_ZERO : p + 19'h00001;
  endfunction

  // Each port is sampled on its own, so rates may differ freely
  sfm_sync #(.W(sfm_pkg::WR_PIN_W)) u_wr_sync (
    .clk(clk),
    .srst(srst),
    .din({input_nibble, input_pointer_clear, input_mask_on, input_advance_gate,
          input_shift_clock}),
    .dout(wr_s),
    .rise(wr_edge)
  );

  sfm_sync #(.W(sfm_pkg::RD_PIN_W)) u_rd_sync (
    .clk(clk),
    .srst(srst),
    .din({output_pointer_clear, output_drive_on, output_advance_gate, output_shift_clock}),
    .dout(rd_s),
    .rise(rd_edge)
  );

  // Staged word goes to storage on the next write edge of any kind, but only if its mask is on
  assign commit = wr_edge & pend_v & pend_mask;

  // Write pointer and one-word staging register
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= sfm_pkg::ADDR_ZERO;
      pend_v <= 1'b0;
      pend_mask <= 1'b0;
      pend_addr <= sfm_pkg::ADDR_ZERO;
      pend_data <= sfm_pkg::DOUT_RESET;
    end else if (wr_edge) begin
      if (wr_s.clear) begin
        wr_ptr <= sfm_pkg::ADDR_ZERO;
        pend_v <= 1'b0;
      end else if (wr_s.gate) begin
        pend_v <= 1'b1;
        pend_mask <= wr_s.mask_on;
        pend_addr <= wr_ptr;
        pend_data <= wr_s.nibble;
        wr_ptr <= ptr_inc(wr_ptr);
      end else begin
        pend_v <= 1'b0;
      end
    end
  end

  // Storage is plain flops, so no refresh stall ever meets a port
  always_ff @(posedge clk) begin
    if (commit) begin
      mem[pend_addr] <= pend_data;
      if (pend_addr < sfm_pkg::OLD_DEPTH) begin
        old_buf[pend_addr[6:0]] <= mem[pend_addr];
      end
    end
  end

  // Old-buffer entries holding a word displaced by the field now being written. Without
  // them a read that runs ahead of the write, or meets a masked word, would see a stale
  // entry. A write reset outranks a commit in the same cycle: that commit closes the
  // field just left, whose word now sits in storage itself.
  always_ff @(posedge clk) begin
    if (srst) begin
      old_sv <= '0;
    end else if (wr_edge && wr_s.clear) begin
      old_sv <= '0;
    end else if (commit && pend_addr < sfm_pkg::OLD_DEPTH) begin
      old_sv[pend_addr[6:0]] <= 1'b1;
    end
  end

  // Write clocks since the last write reset, saturating at the old-data limit
  always_ff @(posedge clk) begin
    if (srst) begin
      since_wrst <= sfm_pkg::OLD_LIMIT;
      fresh <= 1'b0;
    end else if (wr_edge) begin
      if (wr_s.clear) begin
        since_wrst <= 7'h00;
        fresh <= 1'b1;
      end else if (since_wrst != sfm_pkg::OLD_LIMIT) begin
        since_wrst <= since_wrst + 7'h01;
        fresh <= (since_wrst + 7'h01) != sfm_pkg::OLD_LIMIT;
      end
    end
  end

  // Read pointer and old-field selection
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_ptr <= sfm_pkg::ADDR_ZERO;
      use_old <= 1'b0;
    end else if (rd_edge) begin
      if (rd_s.clear) begin
        rd_ptr <= sfm_pkg::ADDR_ZERO;
        use_old <= fresh;
      end else if (rd_s.gate) begin
        rd_ptr <= ptr_inc(rd_ptr);
        if (ptr_inc(rd_ptr) >= sfm_pkg::OLD_DEPTH) begin
          use_old <= 1'b0;
        end
      end
    end
  end

  // Output word; the reset cycle leaves it alone, drive has no say here
  always_ff @(posedge clk) begin
    if (srst) begin
      output_nibble <= sfm_pkg::DOUT_RESET;
    end else if (rd_edge && !rd_s.clear && rd_s.gate) begin
      if (use_old && rd_ptr < sfm_pkg::OLD_DEPTH && old_sv[rd_ptr[6:0]]) begin
        output_nibble <= old_buf[rd_ptr[6:0]];
      end else begin
        output_nibble <= mem[rd_ptr];
      end
    end
  end

  // Drivers follow the synchronised enable
  assign output_nibble_oe = rd_s.drive_on;

  property p_wr_adv;
    @(posedge clk) disable iff (srst)
      (wr_edge && !wr_s.clear && wr_s.gate) |=> (wr_ptr == ptr_inc($past(wr_ptr)));
  endproperty
  a_wr_adv: assert property (p_wr_adv) else $error("write pointer did not advance");

  property p_wr_hold;
    @(posedge clk) disable iff (srst)
      (wr_edge && !wr_s.clear && !wr_s.gate) |=> (wr_ptr == $past(wr_ptr)) && !pend_v;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write pointer moved with gate low");

  property p_wr_mask;
    @(posedge clk) disable iff (srst)
      (wr_edge && !wr_s.clear && wr_s.gate) |=> pend_v && (pend_mask == $past(wr_s.mask_on));
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("mask not carried with word");

  property p_wr_clear;
    @(posedge clk) disable iff (srst)
      (wr_edge && wr_s.clear) |=> (wr_ptr == sfm_pkg::ADDR_ZERO) && !pend_v;
  endproperty
  a_wr_clear: assert property (p_wr_clear) else $error("write reset failed");

  property p_wr_late;
    @(posedge clk) disable iff (srst)
      commit |=> (mem[$past(pend_addr)] == $past(pend_data));
  endproperty
  a_wr_late: assert property (p_wr_late) else $error("staged word not stored");

  property p_rd_adv;
    @(posedge clk) disable iff (srst)
      (rd_edge && !rd_s.clear && rd_s.gate) |=> (rd_ptr == ptr_inc($past(rd_ptr)));
  endproperty
  a_rd_adv: assert property (p_rd_adv) else $error("read pointer did not advance");

  property p_rd_hold;
    @(posedge clk) disable iff (srst)
      (rd_edge && !rd_s.clear && !rd_s.gate) |=> $stable(rd_ptr) && $stable(output_nibble);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read moved with gate low");

  property p_rd_clear;
    @(posedge clk) disable iff (srst)
      (rd_edge && rd_s.clear) |=> (rd_ptr == sfm_pkg::ADDR_ZERO) && $stable(output_nibble);
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read reset failed");

  property p_oe;
    @(posedge clk) disable iff (srst)
      output_nibble_oe == $past(output_drive_on, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("output enable does not follow drive");

  property p_old;
    @(posedge clk) disable iff (srst)
      (rd_edge && rd_s.clear) |=> (use_old == $past(fresh));
  endproperty
  a_old: assert property (p_old) else $error("old field selection wrong");
endmodule // sfm_field_fifo

// ==== sfm_ctrl_model.sv ====
// Controller model driving the write and read shift ports of the field memory
`timescale 1ns/1ns

module sfm_ctrl_model #(
  parameter int HALF = 8  // Half link period in clk cycles, 32 ns
) (
  // Pacing clock
  input wire logic clk,
  // Write port
  output logic input_shift_clock,
  output logic input_advance_gate,
  output logic input_mask_on,
  output logic input_pointer_clear,
  output logic [3:0] input_nibble,
  // Read port
  output logic output_shift_clock,
  output logic output_advance_gate,
  output logic output_drive_on,
  output logic output_pointer_clear
);
  // Shift clocks stand still low between frames
  initial begin
    {input_shift_clock, input_advance_gate, input_mask_on, input_pointer_clear} = 4'h0;
    input_nibble = 4'h0;
    {output_shift_clock, output_advance_gate, output_drive_on, output_pointer_clear} = 4'h0;
  end

  // One write clock; data inverts half way through the high phase, well after the edge
  // is sampled, so a late sample shows up as a wrong word
  task wr_cycle(input logic g, input logic m, input logic c, input logic [3:0] d);
    {input_advance_gate, input_mask_on, input_pointer_clear, input_nibble} = {g, m, c, d};
    repeat (HALF) @(negedge clk);
    input_shift_clock = 1'b1;
    repeat (HALF / 2) @(negedge clk);
    input_nibble = ~d;
    repeat (HALF - HALF / 2) @(negedge clk);
    input_shift_clock = 1'b0;
  endtask

  // One read clock
  task rd_cycle(input logic g, input logic o, input logic c);
    {output_advance_gate, output_drive_on, output_pointer_clear} = {g, o, c};
    repeat (HALF) @(negedge clk);
    output_shift_clock = 1'b1;
    repeat (HALF) @(negedge clk);
    output_shift_clock = 1'b0;
  endtask

  // Reset, dummy clocks and reset per port; writes first so dummy reads meet stored words.
  // The read reset closing the read side is the one that opens the first field read,
  // which keeps 130 read clocks of clear low between read resets
  task power_up;
    wr_cycle(1'b0, 1'b0, 1'b1, 4'h0);
    repeat (130) wr_cycle(1'b1, 1'b1, 1'b0, 4'h5);
    wr_cycle(1'b0, 1'b0, 1'b1, 4'h0);
    rd_cycle(1'b0, 1'b0, 1'b1);
    repeat (130) rd_cycle(1'b1, 1'b1, 1'b0);
  endtask

  // Idle write clocks keep the read reset well clear of the write reset
  task wr_idle(input int n);
    repeat (n) wr_cycle(1'b0, 1'b1, 1'b0, 4'ha);
  endtask
endmodule  // sfm_ctrl_model

// ==== tb_serial_field_fifo_memory.sv ====
// Self-checking bench for the serial field memory with a controller model
`timescale 1ns/1ns

module tb_serial_field_fifo_memory;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic input_shift_clock, input_advance_gate, input_mask_on, input_pointer_clear;
  logic output_shift_clock, output_advance_gate, output_drive_on, output_pointer_clear;
  logic [3:0] input_nibble, output_nibble;
  logic output_nibble_oe;
  logic [3:0] fld [0:2][0:255];  // Expected memory image per field
  int seed = 32'hf5ca;
  int num_errors = 0;
  int cmp_count = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  sfm_field_fifo i_dut (.clk, .srst, .input_shift_clock, .input_advance_gate, .input_mask_on,
    .input_pointer_clear, .input_nibble, .output_shift_clock, .output_advance_gate,
    .output_drive_on, .output_pointer_clear, .output_nibble, .output_nibble_oe);
  sfm_ctrl_model i_ctrl (.clk, .input_shift_clock, .input_advance_gate, .input_mask_on,
    .input_pointer_clear, .input_nibble, .output_shift_clock, .output_advance_gate,
    .output_drive_on, .output_pointer_clear);

  // Masked writes keep the old word
  function automatic logic [3:0] next_word(logic [3:0] old, logic [3:0] d, logic m);
    return m ? d : old;
  endfunction

  // Compare and count
  task check(input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t read mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task close_out;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One field of n active words with random gate and mask, closed by a write reset
  task automatic write_field(input int f, input int n);
    int a;
    logic g, m;
    logic [3:0] d;
    a = 0;
    for (int i = 0; i < 256; i++) begin
      fld[f][i] = (f == 0) ? 4'h5 : fld[(f == 0) ? 0 : f - 1][i];
    end
    while (a < n) begin
      g = ($random(seed) & 3) != 0;
      m = a >= 120 || ($random(seed) & 3) != 0;
      d = 4'($random(seed));
      i_ctrl.wr_cycle(g, m, 1'b0, d);
      if (g) begin
        fld[f][a] = next_word(fld[f][a], d, m);
        a++;
      end
    end
    i_ctrl.wr_cycle(1'($random(seed)), 1'($random(seed)), 1'b1, 4'($random(seed)));
  endtask

  // Read reset then 130 active reads; the first ncmp words are compared
  task automatic read_field(input int f, input int ncmp);
    int a;
    logic g, o;
    a = 0;
    i_ctrl.rd_cycle(1'($random(seed)), 1'($random(seed)), 1'b1);
    while (a < 130) begin
      g = ($random(seed) & 3) != 0;
      o = 1'($random(seed));
      i_ctrl.rd_cycle(g, o, 1'b0);
      a = a + int'(g);
      if (a > 0 && a <= ncmp) check(output_nibble, fld[f][a - 1]);
      check({3'h0, output_nibble_oe}, {3'h0, o});
    end
  endtask

  // Reset, power-up, then fields written and read back
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    check(output_nibble, sfm_pkg::DOUT_RESET);
    check({3'h0, output_nibble_oe}, 4'h0);
    i_ctrl.power_up();
    write_field(0, 140);
    i_ctrl.wr_idle(600);
    repeat (2000) @(negedge clk);  // both clocks stopped
    read_field(0, 130);
    write_field(1, 140);
    fork
      write_field(2, 140);
      read_field(1, 100);  // old field read during a new write
    join
    close_out();
  end

  // Watchdog in case a port hangs
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule  // tb_serial_field_fifo_memory
